// File: verilog/acl_regs.svh
// Constants for the add-with-carry and logic-op execute block.
// Assumes inclusion by bare name from the core.
//
// Contract
// - Match 0010 00da, add W, byte, carry
// - Add result to W or memory by d
// - Bank bit zero access bank, else pointer
// - Extended set, a zero, f<=95: indexed
// - Literal AND into W, N and Z only
// - Match 0001 01da, AND W with byte
// - Register AND stored by d bit
`ifndef ACL_REGS_SVH
`define ACL_REGS_SVH

// ----------------------------------------
// Opcode fields
// ----------------------------------------
`define ACL_ADDC_OPC   6'h08
`define ACL_ANDF_OPC   6'h05
`define ACL_ANDL_OPC   8'h0b

// ----------------------------------------
// Addressing
// ----------------------------------------
`define ACL_IDX_LIMIT  8'h5f
`define ACL_ACC_SPLIT  8'h60
`define ACL_ACC_HIPAGE 4'hf
`define ACL_ACC_LOPAGE 4'h0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACL_WREG_RST   8'h00
`define ACL_ADDR_RST   12'h000

`endif

// File: verilog/acl_pkg.sv
// Types shared by the execute block and its arithmetic unit.
// Assumes nothing beyond the constants header.
package acl_pkg;
	// ----------------------------------------
	// Instruction phases, one-hot
	// ----------------------------------------
	typedef enum logic [3:0]
	{
		PH_Q1 = 4'h1,
		PH_Q2 = 4'h2,
		PH_Q3 = 4'h4,
		PH_Q4 = 4'h8
	} acl_phase_t;

	// ----------------------------------------
	// Decoded operation, one-hot
	// ----------------------------------------
	typedef enum logic [3:0]
	{
		OP_NONE = 4'h1,
		OP_ADDC = 4'h2,
		OP_ANDL = 4'h4,
		OP_ANDF = 4'h8
	} acl_op_t;
endpackage

// File: verilog/acl_alu.sv
// Arithmetic unit: add with carry and bitwise AND, with flag results.
// Assumes the core registers every output it uses.
`timescale 1ns/1ps
module acl_alu
	import acl_pkg::*;
(
	input  wire acl_op_t    opSel,
	input  wire logic [7:0] wIn,
	input  wire logic [7:0] opndIn,
	input  wire logic       cIn,
	input  wire logic       ovfIn,
	input  wire logic       nibCarryIn,
	output logic      [7:0] res,
	output logic            nOut,
	output logic            ovfOut,
	output logic            zOut,
	output logic            nibCarryOut,
	output logic            cOut
);
	logic [8:0] sum9;
	logic [4:0] sumLo;

	always_comb
	begin
		sum9  = {1'b0, wIn} + {1'b0, opndIn} + {8'h00, cIn};
		sumLo = {1'b0, wIn[3:0]} + {1'b0, opndIn[3:0]} + {4'h0, cIn};
		res   = wIn & opndIn;
		ovfOut      = ovfIn;
		nibCarryOut = nibCarryIn;
		cOut        = cIn;
		if (opSel == OP_ADDC)
		begin
			// All five flags follow the sum
			res   = sum9[7:0];
			cOut  = sum9[8];
			nibCarryOut = sumLo[4];
			ovfOut      = (wIn[7] == opndIn[7]) && (sum9[7] != wIn[7]);
		end
		// AND keeps carry, nibble carry and overflow as they were
		nOut = res[7];
		zOut = (res == 8'h00);
	end
endmodule

// File: verilog/acl_core.sv
// Execute block for add-with-carry and the two AND instructions.
// Assumes one mclk per phase, a memory that answers a read in the same
// cycle, and an instruction word held stable during the first phase.
`timescale 1ns/1ps
`include "acl_regs.svh"
module acl_core
	import acl_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [15:0] instrWord,
	input  wire logic        instrValid,
	input  wire logic [3:0]  bankSelectPointer,
	input  wire logic        extendedSetEn,
	input  wire logic [11:0] indexBase,
	input  wire logic [7:0]  memRdData,
	output logic      [11:0] memAddr,
	output logic             memRdEn,
	output logic             memWrEn,
	output logic      [7:0]  memWrData,
	output logic      [7:0]  wreg,
	output logic             negFlag,
	output logic             signedOverflowFlag,
	output logic             zeroFlag,
	output logic             nibbleCarryFlag,
	output logic             carryFlag,
	output logic      [3:0]  qPhase,
	output logic             instrDone,
	output logic             instrUnknown
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	acl_phase_t  phase_q,   phase_d;
	acl_op_t     op_q,      op_d;
	logic [15:0] instr_q,   instr_d;
	logic [11:0] addr_q,    addr_d;
	logic        rdEn_q,    rdEn_d;
	logic        wrEn_q,    wrEn_d;
	logic [7:0]  res_q,     res_d;
	logic [7:0]  wreg_q,    wreg_d;
	logic [4:0]  flags_q,   flags_d;
	logic [4:0]  pend_q,    pend_d;
	logic        done_q,    done_d;
	logic        unk_q,     unk_d;

	logic [7:0]  aluRes;
	logic [7:0]  aluOpnd;
	logic        aluN;
	logic        aluOvf;
	logic        aluZ;
	logic        aluNibCarry;
	logic        aluC;
	logic [7:0]  fField;
	logic        dBit;
	logic        aBit;

	assign fField = instr_q[7:0];
	assign dBit   = instr_q[9];
	assign aBit   = instr_q[8];
	// Literal op reads no memory
	assign aluOpnd = (op_q == OP_ANDL) ? fField : memRdData;

	acl_alu u_alu
	(
		.opSel  (op_q),
		.wIn    (wreg_q),
		.opndIn (aluOpnd),
		.cIn         (flags_q[0]),
		.ovfIn       (flags_q[3]),
		.nibCarryIn  (flags_q[1]),
		.res         (aluRes),
		.nOut        (aluN),
		.ovfOut      (aluOvf),
		.zOut        (aluZ),
		.nibCarryOut (aluNibCarry),
		.cOut        (aluC)
	);

	// ----------------------------------------
	// Phase sequencing and datapath
	// ----------------------------------------
	always_comb
	begin
		phase_d = phase_q;
		op_d    = op_q;
		instr_d = instr_q;
		addr_d  = addr_q;
		rdEn_d  = 1'b0;
		wrEn_d  = 1'b0;
		res_d   = res_q;
		wreg_d  = wreg_q;
		flags_d = flags_q;
		pend_d  = pend_q;
		done_d  = 1'b0;
		unk_d   = unk_q;
		unique case (phase_q)
			PH_Q1:
			begin
				phase_d = PH_Q2;
				instr_d = instrWord;
				op_d    = OP_NONE;
				unk_d   = 1'b0;
				if (instrValid)
				begin
					if (instrWord[15:10] == `ACL_ADDC_OPC)
						op_d = OP_ADDC;
					else if (instrWord[15:8] == `ACL_ANDL_OPC)
						op_d = OP_ANDL;
					else if (instrWord[15:10] == `ACL_ANDF_OPC)
						op_d = OP_ANDF;
					else
						unk_d = 1'b1;
				end
			end
			PH_Q2:
			begin
				phase_d = PH_Q3;
				if (op_q == OP_ADDC || op_q == OP_ANDF)
				begin
					rdEn_d = 1'b1;
					if (aBit)
						addr_d = {bankSelectPointer, fField};
					else if (extendedSetEn && fField <= `ACL_IDX_LIMIT)
						addr_d = 12'(indexBase + {4'h0, fField});
					else if (fField < `ACL_ACC_SPLIT)
						addr_d = {`ACL_ACC_LOPAGE, fField};
					else
						addr_d = {`ACL_ACC_HIPAGE, fField};
				end
			end
			PH_Q3:
			begin
				phase_d = PH_Q4;
				res_d   = aluRes;
				pend_d  = {aluN, aluOvf, aluZ, aluNibCarry, aluC};
				// Memory write is driven through the whole write phase
				if ((op_q == OP_ADDC || op_q == OP_ANDF) && dBit)
					wrEn_d = 1'b1;
			end
			PH_Q4:
			begin
				phase_d = PH_Q1;
				if (op_q != OP_NONE)
				begin
					flags_d = pend_q;
					done_d  = 1'b1;
					if (op_q == OP_ANDL || !dBit)
						wreg_d = res_q;
				end
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			phase_q <= PH_Q1;
			op_q    <= OP_NONE;
			instr_q <= 16'h0000;
			addr_q  <= `ACL_ADDR_RST;
			rdEn_q  <= 1'b0;
			wrEn_q  <= 1'b0;
			res_q   <= 8'h00;
			wreg_q  <= `ACL_WREG_RST;
			flags_q <= 5'h00;
			pend_q  <= 5'h00;
			done_q  <= 1'b0;
			unk_q   <= 1'b0;
		end
		else
		begin
			phase_q <= phase_d;
			op_q    <= op_d;
			instr_q <= instr_d;
			addr_q  <= addr_d;
			rdEn_q  <= rdEn_d;
			wrEn_q  <= wrEn_d;
			res_q   <= res_d;
			wreg_q  <= wreg_d;
			flags_q <= flags_d;
			pend_q  <= pend_d;
			done_q  <= done_d;
			unk_q   <= unk_d;
		end
	end

	assign memAddr            = addr_q;
	assign memRdEn            = rdEn_q;
	assign memWrEn            = wrEn_q;
	assign memWrData          = res_q;
	assign wreg               = wreg_q;
	assign negFlag            = flags_q[4];
	assign signedOverflowFlag = flags_q[3];
	assign zeroFlag           = flags_q[2];
	assign nibbleCarryFlag    = flags_q[1];
	assign carryFlag          = flags_q[0];
	assign qPhase             = phase_q;
	assign instrDone          = done_q;
	assign instrUnknown       = unk_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	logic takeAddc;
	logic takeAndl;
	logic takeAndf;
	assign takeAddc = phase_q == PH_Q1 && instrValid && instrWord[15:10] == `ACL_ADDC_OPC;
	assign takeAndl = phase_q == PH_Q1 && instrValid && instrWord[15:8] == `ACL_ANDL_OPC;
	assign takeAndf = phase_q == PH_Q1 && instrValid && instrWord[15:10] == `ACL_ANDF_OPC;

	phase_order_a: assert property (
		(phase_q == PH_Q1) |-> ##3 (phase_q == PH_Q4) ##1 (phase_q == PH_Q1))
		else $error("phase order broken");
	read_phase_a: assert property (rdEn_q |-> phase_q == PH_Q3)
		else $error("read outside process phase");
	addc_w_a: assert property (
		takeAddc && !instrWord[9] |-> ##4
		(wreg_q == 8'($past(wreg_q, 4) + $past(memRdData, 2)
		+ {7'h00, $past(carryFlag, 4)})))
		else $error("add with carry to W wrong");
	addc_mem_a: assert property (
		takeAddc && instrWord[9] |-> ##3 (memWrEn && $stable(wreg_q)) ##1 $stable(wreg_q))
		else $error("add with carry memory write missing");
	bank_addr_a: assert property (
		takeAddc && instrWord[8] |-> ##2 (memRdEn
		&& memAddr == {$past(bankSelectPointer), $past(instrWord[7:0], 2)}))
		else $error("bank address wrong");
	indexed_addr_a: assert property (
		takeAndf && !instrWord[8] && instrWord[7:0] <= `ACL_IDX_LIMIT ##1 extendedSetEn
		|=> (memAddr == 12'($past(indexBase) + {4'h0, $past(instr_q[7:0])})))
		else $error("indexed address wrong");
	andl_result_a: assert property (
		takeAndl |-> ##4 (wreg_q == ($past(wreg_q, 4) & $past(instrWord[7:0], 4))
		&& carryFlag == $past(carryFlag, 4)
		&& signedOverflowFlag == $past(signedOverflowFlag, 4)))
		else $error("literal AND result or flags wrong");
	andf_flags_a: assert property (
		takeAndf |-> ##4 (zeroFlag == (($past(wreg_q, 4) & $past(memRdData, 2)) == 8'h00)
		&& nibbleCarryFlag == $past(nibbleCarryFlag, 4)))
		else $error("register AND flags wrong");
	andf_dest_a: assert property (
		takeAndf && instrWord[9] |-> ##3 (memWrEn && memWrData == (wreg_q & $past(memRdData))))
		else $error("register AND write back missing");
endmodule

// File: test/tb.sv
// Self-checking bench for the add-with-carry and AND execute block.
// Assumes one phase per mclk and inputs driven at falling edges.
`timescale 1ns/1ps
module tb;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic [15:0] instrWord = 16'h0000;
	logic        instrValid = 1'b0;
	logic [3:0]  bankSelectPointer = 4'h0;
	logic        extendedSetEn = 1'b0;
	logic [11:0] indexBase = 12'h000;
	logic [7:0]  memRdData = 8'h00;
	logic [11:0] memAddr, aAddr;
	logic [7:0]  memWrData, wreg, aWd;
	logic [3:0]  qPhase;
	logic        memRdEn, memWrEn, negFlag, signedOverflowFlag, zeroFlag;
	logic        nibbleCarryFlag, carryFlag, instrDone, instrUnknown, aRe, aWe;
	int          numErrors = 0;
	int          comparisons = 0;
	wire  [4:0]  fl = {negFlag, signedOverflowFlag, carryFlag, nibbleCarryFlag, zeroFlag};

	acl_core DUT (.mclk(mclk), .nrst(nrst), .instrWord(instrWord), .instrValid(instrValid),
		.bankSelectPointer(bankSelectPointer), .extendedSetEn(extendedSetEn),
		.indexBase(indexBase), .memRdData(memRdData), .memAddr(memAddr),
		.memRdEn(memRdEn), .memWrEn(memWrEn), .memWrData(memWrData), .wreg(wreg),
		.negFlag(negFlag), .signedOverflowFlag(signedOverflowFlag), .zeroFlag(zeroFlag),
		.nibbleCarryFlag(nibbleCarryFlag), .carryFlag(carryFlag), .qPhase(qPhase),
		.instrDone(instrDone), .instrUnknown(instrUnknown));

	always #2.5 mclk = ~mclk;

	// ----------------------------------------
	// Shared drivers and compares
	// ----------------------------------------
	task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
		comparisons++;
		if (got !== exp)
		begin
			numErrors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tallyAndFinish;
		$display("comparisons %0d errors %0d", comparisons, numErrors);
		if (numErrors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Entered and left at a falling edge inside Q1
	task automatic exec(input logic [15:0] w, input logic [7:0] rd, input logic known);
		logic regOp;
		logic unk;
		regOp = known && (w[15:8] !== 8'h0b);
		instrWord = w;
		instrValid = 1'b1;
		@(negedge mclk);
		instrValid = 1'b0;
		instrWord = ~w;
		memRdData = rd;
		unk = instrUnknown;
		@(negedge mclk);
		aRe = memRdEn;
		aAddr = memAddr;
		@(negedge mclk);
		memRdData = ~rd;
		aWe = memWrEn;
		aWd = memWrData;
		@(negedge mclk);
		chk("qPhase", 12'h001, 12'(qPhase));
		chk("instrDone", 12'(known), 12'(instrDone));
		chk("instrUnknown", 12'(!known), 12'(unk));
		chk("memRdEn", 12'(regOp), 12'(aRe));
		chk("memWrEn", 12'(regOp && w[9]), 12'(aWe));
	endtask

	task automatic post(input logic [11:0] a, input logic [7:0] wd, input logic [7:0] w,
		input logic [4:0] f);
		if (aRe === 1'b1)
			chk("memAddr", a, aAddr);
		if (aWe === 1'b1)
			chk("memWrData", 12'(wd), 12'(aWd));
		chk("wreg", 12'(w), 12'(wreg));
		chk("flags", 12'(f), 12'(fl));
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_addc;
		bankSelectPointer = 4'h3;
		exec(16'h2005, 8'h4d, 1'b1);
		post(12'h005, 8'h00, 8'h4d, 5'b00000);
		exec(16'h2112, 8'hff, 1'b1);
		post(12'h312, 8'h00, 8'h4c, 5'b00110);
		exec(16'h2112, 8'h02, 1'b1);
		post(12'h312, 8'h00, 8'h4f, 5'b00000);
		exec(16'h2312, 8'h31, 1'b1);
		post(12'h312, 8'h80, 8'h4f, 5'b11010);
	endtask

	// Overflow and nibble carry are still set here, so keeping them is visible
	task automatic s_andl;
		exec(16'h0b30, 8'h55, 1'b1);
		post(12'h000, 8'h00, 8'h00, 5'b01011);
	endtask

	task automatic s_andf;
		exec(16'h2060, 8'hc3, 1'b1);
		post(12'hf60, 8'h00, 8'hc3, 5'b10000);
		extendedSetEn = 1'b1;
		indexBase = 12'hfe0;
		exec(16'h145f, 8'h81, 1'b1);
		post(12'h03f, 8'h00, 8'h81, 5'b10000);
		exec(16'h1660, 8'h7e, 1'b1);
		post(12'hf60, 8'h00, 8'h81, 5'b00001);
	endtask

	task automatic s_unknown;
		exec(16'hffff, 8'h12, 1'b0);
		post(12'h000, 8'h00, 8'h81, 5'b00001);
	endtask

	initial
	begin
		int n;
		n = 0;
		repeat (4) @(negedge mclk);
		nrst = 1'b1;
		@(negedge mclk);
		while (qPhase !== 4'h1 && n < 8)
		begin
			@(negedge mclk);
			n++;
		end
		chk("qPhase", 12'h001, 12'(qPhase));
		chk("wreg", 12'h000, 12'(wreg));
		chk("flags", 12'h000, 12'(fl));
		s_addc;
		s_andl;
		s_andf;
		s_unknown;
		tallyAndFinish;
	end

	// About 44 cycles are needed; the margin covers a stuck phase loop
	initial
	begin
		#2000;
		numErrors++;
		tallyAndFinish;
	end
endmodule
